// ### hdl/charge_sequencer.sv
// Charge phase sequencer with timers and status pin encoding
`timescale 1ns/10ps
`default_nettype none

module charge_sequencer #(
  parameter logic [charge_seq_pkg::TIMER_W-1:0] BAD_WAIT_CYC = charge_seq_pkg::TIMER_W'(charge_seq_pkg::BAD_WAIT_CYC),
  parameter logic [charge_seq_pkg::TIMER_W-1:0] SAFETY_CYC   = charge_seq_pkg::TIMER_W'(charge_seq_pkg::SAFETY_CYC),
  parameter logic [charge_seq_pkg::DEG_W-1:0]   DEGLITCH_CYC = charge_seq_pkg::DEG_W'(charge_seq_pkg::DEGLITCH_CYC),
  parameter logic [charge_seq_pkg::BLINK_W-1:0] NTC_HALF_CYC = charge_seq_pkg::BLINK_W'(charge_seq_pkg::NTC_HALF_CYC),
  parameter logic [charge_seq_pkg::BLINK_W-1:0] BAD_HALF_CYC = charge_seq_pkg::BLINK_W'(charge_seq_pkg::BAD_HALF_CYC)
) (
  // Clock and reset
  input  wire logic SYS_CLK_I,
  input  wire logic RESETN_I,
  // Battery and current comparators
  input  wire logic ABOVE_TRICKLE_THRESHOLD_I,
  input  wire logic ABOVE_RECHARGE_THRESHOLD_I,
  input  wire logic NEAR_FLOAT_I,
  input  wire logic BELOW_TENTH_CURRENT_I,
  // Temperature comparators
  input  wire logic THERMISTOR_SENSE_FAULT_I,
  input  wire logic DIE_HOT_I,
  // Control pins
  input  wire logic HIGH_POWER_SELECT_I,
  input  wire logic SUSPEND_INPUT_I,
  input  wire logic INPUT_UNDERVOLTAGE_LOCK_I,
  input  wire logic DIFFERENTIAL_UNDERVOLTAGE_LOCK_I,
  // Charger control
  output logic                     CHARGE_ENABLE_O,
  output charge_seq_pkg::current_t CURRENT_SELECT_O,
  output logic                     PROGRAM_PIN_1V_O,
  output logic                     CONSTANT_VOLTAGE_O,
  output logic                     THERMAL_REDUCE_O,
  output logic                     BAD_BATTERY_O,
  // Open-drain status pin
  input  wire logic CHARGE_STATUS_OUT_I,
  output logic      CHARGE_STATUS_OUT_O,
  output logic      CHARGE_STATUS_OUT_OEN_O
);
  localparam int PW = charge_seq_pkg::PIN_W;

  logic [PW-1:0] pins_raw;
  logic [PW-1:0] pins_s1_q;
  logic [PW-1:0] pins_q;
  logic above_trk, above_rech, near_float, temp_fault;
  logic die_hot, below_tenth, high_power, run;
  logic run_prev_q, restart;
  charge_seq_pkg::phase_t state_q, state_d;
  logic [charge_seq_pkg::TIMER_W-1:0] trickle_cnt_q, safety_cnt_q;
  logic [charge_seq_pkg::DEG_W-1:0]   below_cnt_q;
  logic bad_latch_q, seen_rech_q, released_q;
  logic trickle_expired, safety_expired, rech_drop, redrop;
  logic charging;
  charge_seq_pkg::status_t status_mode;
  logic drive_low;

  // Pin inputs come from the analogue side, two flops each
  assign pins_raw[charge_seq_pkg::P_ABOVE_TRK]  = ABOVE_TRICKLE_THRESHOLD_I;
  assign pins_raw[charge_seq_pkg::P_ABOVE_RECH] = ABOVE_RECHARGE_THRESHOLD_I;
  assign pins_raw[charge_seq_pkg::P_NEAR_FLOAT] = NEAR_FLOAT_I;
  assign pins_raw[charge_seq_pkg::P_TEMP_FAULT] = THERMISTOR_SENSE_FAULT_I;
  assign pins_raw[charge_seq_pkg::P_DIE_HOT]    = DIE_HOT_I;
  assign pins_raw[charge_seq_pkg::P_BELOW_TEN]  = BELOW_TENTH_CURRENT_I;
  assign pins_raw[charge_seq_pkg::P_HIGH_POWER] = HIGH_POWER_SELECT_I;
  assign pins_raw[charge_seq_pkg::P_SUSPEND]    = SUSPEND_INPUT_I;
  assign pins_raw[charge_seq_pkg::P_INPUT_UNDERVOLTAGE_LOCK_OK]    = INPUT_UNDERVOLTAGE_LOCK_I;
  assign pins_raw[charge_seq_pkg::P_DIFFERENTIAL_UNDERVOLTAGE_LOCK_OK]   = DIFFERENTIAL_UNDERVOLTAGE_LOCK_I;

  // Two-flop synchroniser per pin
  for (genvar g = 0; g < PW; g++) begin : g_sync
    always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
        pins_s1_q[g] <= 1'b0;
        pins_q[g]    <= 1'b0;
      end else begin
        pins_s1_q[g] <= pins_raw[g];
        pins_q[g]    <= pins_s1_q[g];
      end
    end
  end

  // Synchronised levels
  assign above_trk   = pins_q[charge_seq_pkg::P_ABOVE_TRK];
  assign above_rech  = pins_q[charge_seq_pkg::P_ABOVE_RECH];
  assign near_float  = pins_q[charge_seq_pkg::P_NEAR_FLOAT];
  assign temp_fault  = pins_q[charge_seq_pkg::P_TEMP_FAULT];
  assign die_hot     = pins_q[charge_seq_pkg::P_DIE_HOT];
  assign below_tenth = pins_q[charge_seq_pkg::P_BELOW_TEN];
  assign high_power  = pins_q[charge_seq_pkg::P_HIGH_POWER];
  // Both lockouts clear and not suspended
  assign run = pins_q[charge_seq_pkg::P_INPUT_UNDERVOLTAGE_LOCK_OK] & pins_q[charge_seq_pkg::P_DIFFERENTIAL_UNDERVOLTAGE_LOCK_OK]
             & ~pins_q[charge_seq_pkg::P_SUSPEND];

  // Rising run marks a power or suspend cycle
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      run_prev_q <= 1'b0;
    end else begin
      run_prev_q <= run;
    end
  end
  assign restart = run & ~run_prev_q;

  // Timer comparisons
  assign trickle_expired = (trickle_cnt_q == BAD_WAIT_CYC);
  assign safety_expired  = (safety_cnt_q == SAFETY_CYC);
  assign rech_drop       = (below_cnt_q > DEGLITCH_CYC);
  assign redrop          = bad_latch_q & ~seen_rech_q & ~above_trk;

  // Phase selection
  always_comb begin
    state_d = state_q;
    if (!run) begin
      state_d = charge_seq_pkg::ST_OFF;
    end else begin
      unique case (state_q)
        charge_seq_pkg::ST_OFF: begin
          state_d = charge_seq_pkg::ST_TRICKLE;
        end
        charge_seq_pkg::ST_TRICKLE: begin
          if (trickle_expired) begin
            state_d = charge_seq_pkg::ST_BADBAT;
          end else if (above_trk) begin
            state_d = charge_seq_pkg::ST_CC;
          end
        end
        charge_seq_pkg::ST_CC, charge_seq_pkg::ST_CV: begin
          if (redrop) begin
            state_d = charge_seq_pkg::ST_BADBAT;
          end else if (!above_trk) begin
            state_d = charge_seq_pkg::ST_TRICKLE;
          end else if (safety_expired) begin
            state_d = charge_seq_pkg::ST_DONE;
          end else begin
            state_d = near_float ? charge_seq_pkg::ST_CV : charge_seq_pkg::ST_CC;
          end
        end
        charge_seq_pkg::ST_DONE: begin
          if (rech_drop) begin
            state_d = charge_seq_pkg::ST_TRICKLE;
          end
        end
        charge_seq_pkg::ST_BADBAT: begin
          if (above_trk) begin
            state_d = charge_seq_pkg::ST_CC;
          end
        end
        default: state_d = charge_seq_pkg::ST_OFF;
      endcase
    end
  end

  // Phase register
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state_q <= charge_seq_pkg::ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // Time spent in trickle; holds while temperature is bad
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      trickle_cnt_q <= '0;
    end else if (state_q != charge_seq_pkg::ST_TRICKLE || !run) begin
      trickle_cnt_q <= '0;
    end else if (!temp_fault && !trickle_expired) begin
      trickle_cnt_q <= trickle_cnt_q + 1'b1;
    end
  end

  // Deglitch of the recharge comparator; saturates one past the limit
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      below_cnt_q <= '0;
    end else if (above_rech) begin
      below_cnt_q <= '0;
    end else if (!rech_drop) begin
      below_cnt_q <= below_cnt_q + 1'b1;
    end
  end

  // Safety timer: counts only in CV above recharge with good temperature
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      safety_cnt_q <= '0;
    end else if (!run || rech_drop) begin
      safety_cnt_q <= '0;
    end else if (state_q == charge_seq_pkg::ST_CV && above_rech
                 && !temp_fault && !safety_expired) begin
      safety_cnt_q <= safety_cnt_q + 1'b1;
    end
  end

  // Bad battery latch; only a restart clears it
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      bad_latch_q <= 1'b0;
    end else if (state_q == charge_seq_pkg::ST_TRICKLE && trickle_expired && run) begin
      bad_latch_q <= 1'b1;
    end else if (restart) begin
      bad_latch_q <= 1'b0;
    end
  end

  // Has the battery passed recharge since the latch was set
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      seen_rech_q <= 1'b0;
    end else if (restart || (state_q == charge_seq_pkg::ST_TRICKLE && trickle_expired)) begin
      seen_rech_q <= 1'b0;
    end else if (above_rech) begin
      seen_rech_q <= 1'b1;
    end
  end

  // Status release; set wins over the new-cycle clear
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      released_q <= 1'b0;
    end else if ((state_q == charge_seq_pkg::ST_CV && below_tenth && !temp_fault)
                 || state_q == charge_seq_pkg::ST_DONE) begin
      released_q <= 1'b1;
    end else if (state_q == charge_seq_pkg::ST_OFF) begin
      released_q <= 1'b0;
    end
  end

  // Charging phases; temperature pauses without losing the phase
  assign charging = (state_q == charge_seq_pkg::ST_TRICKLE || state_q == charge_seq_pkg::ST_CC
                  || state_q == charge_seq_pkg::ST_CV) && run;

  // Registered charger controls
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      CHARGE_ENABLE_O    <= 1'b0;
      CURRENT_SELECT_O   <= charge_seq_pkg::CUR_NONE;
      PROGRAM_PIN_1V_O   <= 1'b0;
      CONSTANT_VOLTAGE_O <= 1'b0;
      THERMAL_REDUCE_O   <= 1'b0;
      BAD_BATTERY_O      <= 1'b0;
    end else begin
      CHARGE_ENABLE_O    <= charging && !temp_fault;
      CONSTANT_VOLTAGE_O <= charging && state_q == charge_seq_pkg::ST_CV;
      PROGRAM_PIN_1V_O   <= high_power;
      THERMAL_REDUCE_O   <= charging && !temp_fault && die_hot;
      BAD_BATTERY_O      <= bad_latch_q;
      if (!charging || temp_fault) begin
        CURRENT_SELECT_O <= charge_seq_pkg::CUR_NONE;
      end else if (state_q == charge_seq_pkg::ST_TRICKLE) begin
        CURRENT_SELECT_O <= charge_seq_pkg::CUR_TENTH;
      end else begin
        CURRENT_SELECT_O <= high_power ? charge_seq_pkg::CUR_FULL
                                       : charge_seq_pkg::CUR_FIFTH;
      end
    end
  end

  // Status pattern; bad battery is checked ahead of temperature
  always_comb begin
    if (state_q == charge_seq_pkg::ST_OFF || !run || released_q) begin
      status_mode = charge_seq_pkg::STAT_HIZ;
    end else if (state_q == charge_seq_pkg::ST_BADBAT) begin
      status_mode = charge_seq_pkg::STAT_BAD;
    end else if (temp_fault) begin
      status_mode = charge_seq_pkg::STAT_NTC;
    end else begin
      status_mode = charge_seq_pkg::STAT_LOW;
    end
  end

  // Carrier and blink counters share the system clock
  status_pulser #(
    .NTC_HALF (NTC_HALF_CYC),
    .BAD_HALF (BAD_HALF_CYC)
  ) u_pulser (
    .clk_i       (SYS_CLK_I),
    .resetn_i    (RESETN_I),
    .mode_i      (status_mode),
    .drive_low_o (drive_low)
  );

  // Open drain: only ever pulls low; pin level is not read back
  assign CHARGE_STATUS_OUT_O     = 1'b0;
  assign CHARGE_STATUS_OUT_OEN_O = ~drive_low;

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RESETN_I);

  a_trickle_tenth: assert property (
    (state_q == charge_seq_pkg::ST_TRICKLE && run && !temp_fault)
      |=> CURRENT_SELECT_O == charge_seq_pkg::CUR_TENTH)
    else $error("trickle current not one tenth");

  a_cc_entry: assert property (
    (state_q == charge_seq_pkg::ST_TRICKLE && run && above_trk && !trickle_expired)
      |=> state_q == charge_seq_pkg::ST_CC)
    else $error("no constant current after trickle");

  a_bad_latch: assert property (
    (state_q == charge_seq_pkg::ST_TRICKLE && run && trickle_expired)
      |=> bad_latch_q && state_q == charge_seq_pkg::ST_BADBAT ##1 !CHARGE_ENABLE_O)
    else $error("bad battery not latched");

  a_redrop_now: assert property (
    (state_q == charge_seq_pkg::ST_CC && run && redrop)
      |=> state_q == charge_seq_pkg::ST_BADBAT)
    else $error("redrop not declared defective");

  a_latch_hold: assert property (
    (bad_latch_q && !restart) |=> bad_latch_q)
    else $error("bad battery latch lost");

  a_safety_count: assert property (
    (state_q == charge_seq_pkg::ST_CV && run && above_rech && !temp_fault
     && !safety_expired && !rech_drop)
      |=> safety_cnt_q == $past(safety_cnt_q) + 1'b1)
    else $error("safety timer not counting");

  a_expiry_stop: assert property (
    (state_q == charge_seq_pkg::ST_DONE) |=> !CHARGE_ENABLE_O)
    else $error("current after termination");

  a_auto_recharge: assert property (
    (state_q == charge_seq_pkg::ST_DONE && run && rech_drop)
      |=> state_q == charge_seq_pkg::ST_TRICKLE && safety_cnt_q == '0)
    else $error("no recharge after drop");

  a_deglitch_keep: assert property (
    (run && !rech_drop && safety_cnt_q != '0) |=> safety_cnt_q != '0)
    else $error("short drop reset the safety timer");

  a_restart_cycle: assert property (
    restart |=> state_q == charge_seq_pkg::ST_TRICKLE && safety_cnt_q == '0)
    else $error("restart did not begin a cycle");

  a_temp_pause: assert property (
    temp_fault |=> !CHARGE_ENABLE_O)
    else $error("charging during temperature fault");

  a_timer_hold: assert property (
    (temp_fault && run && !rech_drop) |=> $stable(safety_cnt_q))
    else $error("safety timer moved during temperature fault");

  a_suspend_off: assert property (
    !run |=> state_q == charge_seq_pkg::ST_OFF && safety_cnt_q == '0 ##1 !CHARGE_ENABLE_O)
    else $error("suspend did not disable charger");

  a_status_low: assert property (
    (status_mode == charge_seq_pkg::STAT_LOW) |=> !CHARGE_STATUS_OUT_OEN_O)
    else $error("status not low while charging");

  a_status_release: assert property (
    (released_q || status_mode == charge_seq_pkg::STAT_HIZ) |=> CHARGE_STATUS_OUT_OEN_O)
    else $error("status not released");

  a_bad_first: assert property (
    (state_q == charge_seq_pkg::ST_BADBAT && run && !released_q)
      |-> status_mode == charge_seq_pkg::STAT_BAD)
    else $error("bad battery pattern not shown");

  c_bad_battery: cover property (state_q == charge_seq_pkg::ST_BADBAT);
  c_terminated:  cover property (state_q == charge_seq_pkg::ST_DONE);
  c_recharge:    cover property (state_q == charge_seq_pkg::ST_DONE ##1
                                 state_q == charge_seq_pkg::ST_TRICKLE);
  c_ntc_pulse:   cover property (status_mode == charge_seq_pkg::STAT_NTC
                                 && $rose(CHARGE_STATUS_OUT_OEN_O));
endmodule : charge_sequencer
`default_nettype wire

// ### hdl/charge_seq_pkg.sv
// Shared constants and types plus the status pin pulse encoder
`timescale 1ns/10ps
`default_nettype none

package charge_seq_pkg;
  // Clock and unit scales
  localparam longint CLK_HZ        = 250_000_000;
  localparam longint US_PER_S      = 1_000_000;
  localparam longint MHZ_PER_HZ    = 1000;
  // Times, rates and the slot count in their own units
  localparam longint BAD_WAIT_S    = 1800;
  localparam longint SAFETY_S      = 14400;
  localparam longint DEGLITCH_US   = 1700;
  localparam longint CARRIER_HZ    = 35_000;
  localparam longint NTC_BLINK_MHZ = 1500;
  localparam longint BAD_BLINK_MHZ = 6100;
  localparam longint CARRIER_SLOTS = 16;
  // Cycle counts derived from the clock rate; carrier and blink times round down, deglitch rounds up
  localparam longint BAD_WAIT_CYC  = BAD_WAIT_S * CLK_HZ;
  localparam longint SAFETY_CYC    = SAFETY_S * CLK_HZ;
  localparam longint DEGLITCH_CYC  = (DEGLITCH_US * CLK_HZ + US_PER_S - 1) / US_PER_S;
  localparam longint SLOT_CYC      = CLK_HZ / (CARRIER_HZ * CARRIER_SLOTS);
  localparam longint NTC_HALF_CYC  = CLK_HZ * MHZ_PER_HZ / (2 * NTC_BLINK_MHZ);
  localparam longint BAD_HALF_CYC  = CLK_HZ * MHZ_PER_HZ / (2 * BAD_BLINK_MHZ);
  // Counter widths
  localparam int TIMER_W = 42;
  localparam int DEG_W   = 20;
  localparam int BLINK_W = 27;
  localparam int SLOT_W  = 9;
  // Duty cycles in sixteenths of a carrier period (pin pulled low)
  localparam logic [3:0] NTC_DUTY_LO = 4'h1;
  localparam logic [3:0] NTC_DUTY_HI = 4'hf;
  localparam logic [3:0] BAD_DUTY_LO = 4'h2;
  localparam logic [3:0] BAD_DUTY_HI = 4'he;
  // Bit positions in the synchronised pin vector
  localparam int PIN_W        = 10;
  localparam int P_ABOVE_TRK  = 0;
  localparam int P_ABOVE_RECH = 1;
  localparam int P_NEAR_FLOAT = 2;
  localparam int P_TEMP_FAULT = 3;
  localparam int P_DIE_HOT    = 4;
  localparam int P_BELOW_TEN  = 5;
  localparam int P_HIGH_POWER = 6;
  localparam int P_SUSPEND    = 7;
  localparam int P_INPUT_UNDERVOLTAGE_LOCK_OK    = 8;
  localparam int P_DIFFERENTIAL_UNDERVOLTAGE_LOCK_OK   = 9;

  typedef enum logic [2:0] {
    ST_OFF     = 3'b000,
    ST_TRICKLE = 3'b001,
    ST_CC      = 3'b010,
    ST_CV      = 3'b011,
    ST_DONE    = 3'b100,
    ST_BADBAT  = 3'b101
  } phase_t;

  typedef enum logic [1:0] {
    CUR_NONE  = 2'b00,
    CUR_TENTH = 2'b01,
    CUR_FIFTH = 2'b10,
    CUR_FULL  = 2'b11
  } current_t;

  typedef enum logic [1:0] {
    STAT_HIZ = 2'b00,
    STAT_LOW = 2'b01,
    STAT_NTC = 2'b10,
    STAT_BAD = 2'b11
  } status_t;
endpackage : charge_seq_pkg

module status_pulser #(
  parameter logic [charge_seq_pkg::BLINK_W-1:0] NTC_HALF = charge_seq_pkg::BLINK_W'(charge_seq_pkg::NTC_HALF_CYC),
  parameter logic [charge_seq_pkg::BLINK_W-1:0] BAD_HALF = charge_seq_pkg::BLINK_W'(charge_seq_pkg::BAD_HALF_CYC)
) (
  // Clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    resetn_i,
  // Requested pattern and pin drive
  input  wire charge_seq_pkg::status_t mode_i,
  output logic                         drive_low_o
);
  localparam logic [charge_seq_pkg::SLOT_W-1:0] SLOT_LAST =
    charge_seq_pkg::SLOT_W'(charge_seq_pkg::SLOT_CYC - 1);

  logic [charge_seq_pkg::SLOT_W-1:0]  slot_cnt_q;
  logic [3:0]                         slot_idx_q;
  logic [charge_seq_pkg::BLINK_W-1:0] blink_cnt_q;
  logic                               blink_hi_q;
  charge_seq_pkg::status_t            mode_q;
  logic [charge_seq_pkg::BLINK_W-1:0] half_last;
  logic [3:0]                         duty;

  // One clock base feeds both the carrier and the blink
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      slot_cnt_q <= '0;
      slot_idx_q <= 4'h0;
    end else if (slot_cnt_q == SLOT_LAST) begin
      slot_cnt_q <= '0;
      slot_idx_q <= slot_idx_q + 4'h1;
    end else begin
      slot_cnt_q <= slot_cnt_q + 1'b1;
    end
  end

  // Blink phase restarts on a pattern change so each half is whole
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      blink_cnt_q <= '0;
      blink_hi_q  <= 1'b0;
      mode_q      <= charge_seq_pkg::STAT_HIZ;
    end else begin
      mode_q <= mode_i;
      if (mode_i != mode_q) begin
        blink_cnt_q <= '0;
        blink_hi_q  <= 1'b0;
      end else if (blink_cnt_q == half_last) begin
        blink_cnt_q <= '0;
        blink_hi_q  <= ~blink_hi_q;
      end else begin
        blink_cnt_q <= blink_cnt_q + 1'b1;
      end
    end
  end

  // Duty for the current half of the blink
  always_comb begin
    half_last = (mode_i == charge_seq_pkg::STAT_BAD) ? BAD_HALF - 1'b1 : NTC_HALF - 1'b1;
    if (mode_i == charge_seq_pkg::STAT_BAD) begin
      duty = blink_hi_q ? charge_seq_pkg::BAD_DUTY_HI : charge_seq_pkg::BAD_DUTY_LO;
    end else begin
      duty = blink_hi_q ? charge_seq_pkg::NTC_DUTY_HI : charge_seq_pkg::NTC_DUTY_LO;
    end
  end

  // Registered pin drive
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      drive_low_o <= 1'b0;
    end else begin
      unique case (mode_i)
        charge_seq_pkg::STAT_HIZ: drive_low_o <= 1'b0;
        charge_seq_pkg::STAT_LOW: drive_low_o <= 1'b1;
        charge_seq_pkg::STAT_NTC,
        charge_seq_pkg::STAT_BAD: drive_low_o <= (slot_idx_q < duty);
      endcase
    end
  end
endmodule : status_pulser
`default_nettype wire

// ### bench/status_monitor.sv
// Reader of the open-drain status line: low duty per carrier in sixteenths
`timescale 1ns/10ps
`default_nettype none

module status_monitor #(
  parameter int SLOT = 446
) (
  // Clock and pulled-up line
  input  wire logic       clk_i,
  input  wire logic       pin_i,
  // Last accepted reading
  output logic [4:0]      duty_o = 5'h0,
  output logic            new_o  = 1'b0
);
  int   low_q  = 0;
  int   per_q  = 0;
  logic last_q = 1'b1;

  // Falling edge closes a reading; only whole carriers count
  always_ff @(posedge clk_i) begin
    last_q <= pin_i;
    new_o  <= 1'b0;
    if (last_q && !pin_i) begin
      per_q <= 1;
      low_q <= 1;
      // Half duty straddles a blink edge, so it is thrown away
      if (per_q == 16 * SLOT && 2 * low_q != per_q) begin
        duty_o <= 5'((low_q + SLOT / 2) / SLOT);
        new_o  <= 1'b1;
      end
    end else begin
      per_q <= per_q + 1;
      low_q <= low_q + int'(!pin_i);
    end
  end
endmodule : status_monitor

`default_nettype wire

// ### bench/liion_charge_sequencer_tb.sv
// Self-checking bench for the charge sequencer
`timescale 1ns/10ps
`default_nettype none

module liion_charge_sequencer_tb;
  logic clk = 1'b0, rst_n = 1'b0, trk = 1'b0, rch = 1'b0, flt = 1'b0, tenth = 1'b0;
  logic thermistor_sense = 1'b0, hot = 1'b0, hp = 1'b0, suspend_input = 1'b0, uv = 1'b1, duv = 1'b1;
  logic en, pin1v, cv, red, bad, dout, oen, mnew;
  logic [4:0] mduty;
  charge_seq_pkg::current_t sel;
  int fails = 0;
  int num_checks = 0;
  // Pull-up wins whenever the pin is released
  wire logic pin = oen ? 1'b1 : dout;

  always #2 clk = ~clk;

  charge_sequencer #(.BAD_WAIT_CYC(42'h190), .SAFETY_CYC(42'h258), .DEGLITCH_CYC(20'h14),
    .NTC_HALF_CYC(27'h3e80), .BAD_HALF_CYC(27'h3a98)) i_charge_sequencer (
    .SYS_CLK_I(clk), .RESETN_I(rst_n), .ABOVE_TRICKLE_THRESHOLD_I(trk),
    .ABOVE_RECHARGE_THRESHOLD_I(rch), .NEAR_FLOAT_I(flt), .BELOW_TENTH_CURRENT_I(tenth),
    .THERMISTOR_SENSE_FAULT_I(thermistor_sense), .DIE_HOT_I(hot), .HIGH_POWER_SELECT_I(hp),
    .SUSPEND_INPUT_I(suspend_input), .INPUT_UNDERVOLTAGE_LOCK_I(uv),
    .DIFFERENTIAL_UNDERVOLTAGE_LOCK_I(duv), .CHARGE_ENABLE_O(en), .CURRENT_SELECT_O(sel),
    .PROGRAM_PIN_1V_O(pin1v), .CONSTANT_VOLTAGE_O(cv), .THERMAL_REDUCE_O(red),
    .BAD_BATTERY_O(bad), .CHARGE_STATUS_OUT_I(pin), .CHARGE_STATUS_OUT_O(dout),
    .CHARGE_STATUS_OUT_OEN_O(oen));

  status_monitor i_status_monitor (.clk_i(clk), .pin_i(pin), .duty_o(mduty), .new_o(mnew));

  // Current expected in constant current from the power select
  function automatic charge_seq_pkg::current_t cc_sel(input logic h);
    return h ? charge_seq_pkg::CUR_FULL : charge_seq_pkg::CUR_FIFTH;
  endfunction : cc_sel

  task automatic check(input logic [3:0] s, input logic [3:0] e);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask : check

  // Inputs change 1 ns after the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  // Both duty values must show within 36000 cycles, a little over one blink period
  task automatic blink(input logic [4:0] lo, input logic [4:0] hi);
    int a = 0;
    int b = 0;
    repeat (36000) begin
      @(posedge clk);
      if (mnew) begin
        a += int'(mduty === lo);
        b += int'(mduty === hi);
      end
    end
    #1;
    check(4'({a > 0, b > 0}), 4'h3);
  endtask : blink

  task automatic test_done;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done

  // Hang guard: planned run is about 75000 cycles, kept under 100000
  initial begin
    repeat (90000) @(posedge clk);
    fails++;
    test_done();
  end

  initial begin
    int lows = 0;
    void'($urandom(32'h90de));
    cyc(10);
    check({en, sel, oen}, {1'b0, charge_seq_pkg::CUR_NONE, 1'b1});
    check(dout, 1'b0);
    rst_n = 1'b1;
    cyc(6);
    check({en, sel, oen}, {1'b1, charge_seq_pkg::CUR_TENTH, 1'b0});
    hot = 1'b1;
    cyc(6);
    check(red, 1'b1);
    hot = 1'b0;
    trk = 1'b1;
    // Random power select, both levels likely
    repeat (4) begin
      hp = 1'($urandom);
      cyc(6);
      check({en, sel, oen}, {1'b1, cc_sel(hp), 1'b0});
      check(pin1v, hp);
    end
    rch = 1'b1;
    flt = 1'b1;
    cyc(6);
    check(cv, 1'b1);
    cyc(300);
    thermistor_sense = 1'b1;
    cyc(400);
    thermistor_sense = 1'b0;
    cyc(6);
    check(en, 1'b1);
    tenth = 1'b1;
    cyc(6);
    check({en, oen}, 2'b11);
    // Fault after release must not pull the pin
    thermistor_sense = 1'b1;
    repeat (400) begin
      cyc(1);
      lows += int'(oen !== 1'b1);
    end
    thermistor_sense = 1'b0;
    check(4'(lows), 4'h0);
    cyc(350);
    check({en, oen}, 2'b01);
    rch = 1'b0;
    cyc(1 + $urandom % 15);
    rch = 1'b1;
    cyc(40);
    check(en, 1'b0);
    rch = 1'b0;
    cyc(40);
    check(en, 1'b1);
    tenth = 1'b0;
    flt = 1'b0;
    suspend_input = 1'b1;
    cyc(6);
    check(en, 1'b0);
    suspend_input = 1'b0;
    cyc(6);
    check({en, oen}, 2'b10);
    uv = 1'b0;
    cyc(6);
    check(en, 1'b0);
    uv = 1'b1;
    cyc(6);
    check(en, 1'b1);
    thermistor_sense = 1'b1;
    cyc(6);
    check(en, 1'b0);
    blink(5'h1, 5'hf);
    thermistor_sense = 1'b0;
    trk = 1'b0;
    cyc(420);
    check({en, bad}, 2'b01);
    thermistor_sense = 1'b1;
    blink(5'h2, 5'he);
    thermistor_sense = 1'b0;
    trk = 1'b1;
    cyc(6);
    check({en, bad}, 2'b11);
    trk = 1'b0;
    cyc(6);
    check({en, bad}, 2'b01);
    suspend_input = 1'b1;
    cyc(6);
    suspend_input = 1'b0;
    cyc(6);
    check({en, bad}, 2'b10);
    test_done();
  end
endmodule : liion_charge_sequencer_tb

`default_nettype wire
